// [verilog/flp_pkg.sv]
// Constants shared by the flash write-protection block and its area map.
// Assumes a 250 MHz core clock and a command framing layer in front of it.
package flp_pkg;

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [7:0] FLP_CMD_ARM_WRITE    = 8'h06;
	localparam logic [7:0] FLP_CMD_DISARM_WRITE = 8'h04;
	localparam logic [7:0] FLP_CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] FLP_CMD_PAGE_WRITE   = 8'h02;
	localparam logic [7:0] FLP_CMD_SMALL_WIPE   = 8'h20;
	localparam logic [7:0] FLP_CMD_MID_WIPE     = 8'h52;
	localparam logic [7:0] FLP_CMD_LARGE_WIPE   = 8'hD8;
	localparam logic [7:0] FLP_CMD_CHIP_WIPE_A  = 8'hC7;
	localparam logic [7:0] FLP_CMD_CHIP_WIPE_B  = 8'h60;
	localparam logic [7:0] FLP_CMD_SEC_WIPE     = 8'h44;
	localparam logic [7:0] FLP_CMD_SEC_WRITE    = 8'h42;
	localparam logic [7:0] FLP_CMD_SLEEP        = 8'hB9;
	localparam logic [7:0] FLP_CMD_WAKE         = 8'hAB;
	localparam logic [7:0] FLP_CMD_RESET_ARM    = 8'h66;
	localparam logic [7:0] FLP_CMD_RESET_GO     = 8'h99;
	localparam logic [7:0] FLP_CMD_GLOBAL_LOCK  = 8'h7E;
	localparam logic [7:0] FLP_CMD_GLOBAL_FREE  = 8'h98;

	// ****************************************************************
	// Status word field positions
	// ****************************************************************
	localparam int FLP_POS_BUSY     = 0;
	localparam int FLP_POS_WLATCH   = 1;
	localparam int FLP_POS_AREA_LO  = 2;
	localparam int FLP_POS_GUARD_LO = 7;
	localparam int FLP_POS_GUARD_HI = 8;
	localparam int FLP_POS_QUAD     = 9;
	localparam int FLP_POS_LOCK_ONE = 11;
	localparam int FLP_POS_LOCK_TWO = 12;
	localparam int FLP_POS_INVERT   = 14;
	localparam int FLP_POS_LATENCY  = 17;
	localparam int FLP_POS_SCHEME   = 18;
	localparam int FLP_POS_DRIVE_LO = 21;
	localparam int FLP_POS_PIN_FUNC = 23;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [1:0]  FLP_RST_DRIVE     = 2'h2;
	localparam logic [4:0]  FLP_RST_AREA      = 5'h00;
	localparam logic [1:0]  FLP_RST_GUARD     = 2'h0;
	localparam logic [1:0]  FLP_RST_OTP_LOCK  = 2'h0;
	localparam logic [15:0] FLP_RST_BLK_LOCK  = 16'hFFFF;

	// ****************************************************************
	// Address geometry
	// ****************************************************************
	localparam logic [19:0] FLP_SPAN_PAGE  = 20'h000FF;
	localparam logic [19:0] FLP_SPAN_SMALL = 20'h00FFF;
	localparam logic [19:0] FLP_SPAN_MID   = 20'h07FFF;
	localparam logic [19:0] FLP_SPAN_LARGE = 20'h0FFFF;
	localparam int          FLP_SHIFT_SECTOR = 12;
	localparam int          FLP_SHIFT_BLOCK  = 16;
	localparam int          FLP_SEC_SELECT   = 12;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int          FLP_CLK_MHZ    = 250;
	localparam int          FLP_OP_TIME_NS = 64;
	localparam logic [7:0]  FLP_OP_CYCLES  = 8'((FLP_OP_TIME_NS * FLP_CLK_MHZ) / 1000);

	// Operation kinds reported to the array sequencer
	typedef enum logic [2:0] {
		FLP_OP_NONE   = 3'h0,
		FLP_OP_STATUS = 3'h1,
		FLP_OP_PROG   = 3'h3,
		FLP_OP_ERASE  = 3'h2,
		FLP_OP_CHIP   = 3'h6,
		FLP_OP_SECREG = 3'h7
	} flp_op_t;

endpackage

// [verilog/flp_area_map.sv]
// Protected-area decoder: tells whether an address range touches the guarded area.
// Assumes lo and hi lie in one 64KB block and are aligned to the operation size.
`timescale 1ns/1ps
module flp_area_map (
	input  wire logic [4:0]  i_area_guard,
	input  wire logic        i_invert_protect_flag,
	input  wire logic        i_lock_scheme_select,
	input  wire logic [15:0] i_blk_lock,
	input  wire logic [19:0] i_lo,
	input  wire logic [19:0] i_hi,
	output wire logic        o_hit,
	output wire logic        o_chip_ok
);

	// ****************************************************************
	// Non-inverted region geometry
	// ****************************************************************
	// Region is a power-of-two span at the top or bottom of the array
	wire logic [2:0] low3      = i_area_guard[2:0];
	wire logic       none_sel  = (low3 == 3'h0);
	wire logic       all_sel   = (low3[2:1] == 2'h3) || (low3 == 3'h5 && !i_area_guard[4]);
	wire logic [1:0] step      = low3[2] ? 2'h3 : 2'(low3[1:0] - 2'h1);
	wire logic [4:0] shift     = 5'(i_area_guard[4] ? flp_pkg::FLP_SHIFT_SECTOR
	                                                : flp_pkg::FLP_SHIFT_BLOCK) + 5'(step);
	wire logic [20:0] size     = 21'h000001 << shift;
	wire logic [20:0] top_base = 21'h100000 - size;

	// Membership of one address in the non-inverted region
	function automatic logic in_region(input logic [19:0] a);
		if (none_sel)
			in_region = 1'b0;
		else if (all_sel)
			in_region = 1'b1;
		else if (i_area_guard[3])
			in_region = {1'b0, a} < size;      // Bottom
		else
			in_region = {1'b0, a} >= top_base; // Top
	endfunction

	// ****************************************************************
	// Hit and whole-array decision
	// ****************************************************************
	// Region sits at an edge, so checking both ends catches any overlap
	wire logic lo_in   = in_region(i_lo);
	wire logic hi_in   = in_region(i_hi);
	wire logic map_hit = i_invert_protect_flag ? !(lo_in && hi_in) : (lo_in || hi_in);
	// Scheme one uses the block locks, which all default to locked
	assign o_hit     = i_lock_scheme_select ? i_blk_lock[i_lo[19:16]] : map_hit;
	assign o_chip_ok = i_lock_scheme_select ? (i_blk_lock == 16'h0000)
	                 : ((low3 == 3'h0) && !i_invert_protect_flag) ||
	                   ((low3 == 3'h7) && i_invert_protect_flag);

endmodule

// [verilog/flp_write_protect.sv]
// Write and erase protection core of a serial NOR flash: status word, guards, latch, busy.
// Assumes an upstream framer delivers whole, byte-aligned commands as one-cycle strobes,
// and that i_rst stands for a power cycle.
`timescale 1ns/1ps

// What this block does
// - Security lock bits reset to zero
// - Lock bits set individually, never clear
// - Quad enable swaps protect pins to data
// - Guards 00: status write needs latch only
// - Guards 01, pin low: reject status writes
// - Guards 01, pin high: accept with latch
// - Guards 10: locked until power cycle
// - Guards 11: rejected until power cycle
// - Area bits change only when unprotected
// - Refuse program/erase inside guarded area
// - Chip erase only for matching patterns
// - Latch clear: ignore write-class commands
// - Busy flag tracks internal operations
// - Latch set by arm, cleared by listed
// - Deep sleep passes only wake, reset
// - Map: none, all, top/bottom selection
// - Bit four picks block or sector sizes
// - Invert flag complements the protected map
// - Scheme one uses locks defaulting locked
module flp_write_protect (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_cmd_valid,
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic [23:0] i_cmd_addr,
	input  wire logic [23:0] i_cmd_data,
	input  wire logic        i_wp_n,
	output wire logic [23:0] o_status,
	output wire logic        o_internal_op_busy,
	output wire logic        o_write_latch_flag,
	output wire logic        o_deep_sleep,
	output wire logic        o_quad_lines_active,
	output wire logic        o_otp_lock_one,
	output wire logic        o_otp_lock_two,
	output logic             o_op_start,
	output flp_pkg::flp_op_t o_op_kind,
	output logic [23:0]      o_op_addr,
	output logic             o_cmd_refused
);

	// ****************************************************************
	// State
	// ****************************************************************
	// Non-volatile fields first
	// One flop per field, written together
	logic [1:0]  otp_lock_q;
	logic        quad_lanes_enable_q;
	logic [1:0]  status_guard_q;     // {high, low}
	logic [4:0]  area_guard_q;
	logic        invert_protect_flag_q;
	logic        lock_scheme_select_q;
	logic        latency_q;
	logic [1:0]  drive_q;
	logic        pin_func_q;
	// Volatile state below
	logic        write_latch_flag_q;
	logic [7:0]  busy_cnt_q;
	logic        deep_sleep_q;
	logic        reset_armed_q;
	logic [15:0] blk_lock_q;

	// ****************************************************************
	// Command decode
	// ****************************************************************
	// One compare per opcode
	// Unknown codes change nothing but the reset arm
	wire logic is_arm    = (i_cmd_code == flp_pkg::FLP_CMD_ARM_WRITE);
	wire logic is_disarm = (i_cmd_code == flp_pkg::FLP_CMD_DISARM_WRITE);
	wire logic is_swr    = (i_cmd_code == flp_pkg::FLP_CMD_STATUS_WRITE);
	wire logic is_page   = (i_cmd_code == flp_pkg::FLP_CMD_PAGE_WRITE);
	wire logic is_small  = (i_cmd_code == flp_pkg::FLP_CMD_SMALL_WIPE);
	wire logic is_mid    = (i_cmd_code == flp_pkg::FLP_CMD_MID_WIPE);
	wire logic is_large  = (i_cmd_code == flp_pkg::FLP_CMD_LARGE_WIPE);
	wire logic is_chip   = (i_cmd_code == flp_pkg::FLP_CMD_CHIP_WIPE_A) ||
	                       (i_cmd_code == flp_pkg::FLP_CMD_CHIP_WIPE_B);
	wire logic is_sec    = (i_cmd_code == flp_pkg::FLP_CMD_SEC_WIPE) ||
	                       (i_cmd_code == flp_pkg::FLP_CMD_SEC_WRITE);
	wire logic is_sleep  = (i_cmd_code == flp_pkg::FLP_CMD_SLEEP);
	wire logic is_wake   = (i_cmd_code == flp_pkg::FLP_CMD_WAKE);
	wire logic is_rarm   = (i_cmd_code == flp_pkg::FLP_CMD_RESET_ARM);
	wire logic is_rgo    = (i_cmd_code == flp_pkg::FLP_CMD_RESET_GO);
	wire logic is_glock  = (i_cmd_code == flp_pkg::FLP_CMD_GLOBAL_LOCK);
	wire logic is_gfree  = (i_cmd_code == flp_pkg::FLP_CMD_GLOBAL_FREE);
	// Classes for acceptance and latch
	wire logic is_region = is_page || is_small || is_mid || is_large;
	wire logic is_wclass = is_swr || is_region || is_chip || is_sec;

	// Sleep gate first, then latch and busy
	// Deep sleep lets only wake and the reset pair through
	wire logic live     = i_cmd_valid &&
	                      (!deep_sleep_q || is_wake || is_rarm || is_rgo);
	wire logic busy     = (busy_cnt_q != 8'h00);
	// Reset pair needs 66 just before 99
	wire logic soft_rst = live && is_rgo && reset_armed_q;
	// A write-class command is considered only with the latch set and no operation running
	wire logic wr_try   = live && is_wclass && write_latch_flag_q && !busy;

	// ****************************************************************
	// Status write guard
	// ****************************************************************
	// With quad lanes on, the protect pin is a data line and cannot hold the lock
	wire logic wp_level   = quad_lanes_enable_q ? 1'b1 : i_wp_n;
	// Guards 01, pin low: hardware lock
	// Guards 10 and 11 never open
	wire logic hw_protect = (status_guard_q == 2'h1) && !wp_level;
	wire logic guard_open = (status_guard_q == 2'h0) ||
	                        ((status_guard_q == 2'h1) && wp_level);

	// ****************************************************************
	// Area check
	// ****************************************************************
	// Align down to the operation size
	// Bits above the 1MB array are ignored
	// Only the two ends are checked: cheap
	wire logic [19:0] span = is_page  ? flp_pkg::FLP_SPAN_PAGE :
	                         is_small ? flp_pkg::FLP_SPAN_SMALL :
	                         is_mid   ? flp_pkg::FLP_SPAN_MID : flp_pkg::FLP_SPAN_LARGE;
	// First and last byte touched
	wire logic [19:0] lo   = i_cmd_addr[19:0] & ~span;
	wire logic [19:0] hi   = lo | span;
	wire logic        area_hit;
	wire logic        chip_ok;

	// Decoder for both schemes, area map and block locks
	flp_area_map u_map (
		.i_area_guard          (area_guard_q),
		.i_invert_protect_flag (invert_protect_flag_q),
		.i_lock_scheme_select  (lock_scheme_select_q),
		.i_blk_lock            (blk_lock_q),
		.i_lo                  (lo),
		.i_hi                  (hi),
		.o_hit                 (area_hit),
		.o_chip_ok             (chip_ok)
	);

	// Security register chosen by one address bit; locked ones are read-only
	// Set locks never clear
	wire logic sec_idx    = i_cmd_addr[flp_pkg::FLP_SEC_SELECT];
	wire logic sec_locked = otp_lock_q[sec_idx];

	// ****************************************************************
	// Acceptance
	// ****************************************************************
	// Any one failing term refuses
	// A refusal still drops the latch
	wire logic ok_swr    = wr_try && is_swr && guard_open && !hw_protect;
	wire logic ok_region = wr_try && is_region && !area_hit;
	wire logic ok_chip   = wr_try && is_chip && chip_ok;
	wire logic ok_sec    = wr_try && is_sec && !sec_locked;
	wire logic accept    = ok_swr || ok_region || ok_chip || ok_sec;

	// Kind handed to the array sequencer
	wire flp_pkg::flp_op_t kind_now =
		is_swr  ? flp_pkg::FLP_OP_STATUS :
		is_page ? flp_pkg::FLP_OP_PROG :
		is_chip ? flp_pkg::FLP_OP_CHIP :
		is_sec  ? flp_pkg::FLP_OP_SECREG : flp_pkg::FLP_OP_ERASE;

	// Next values of the status fields on an accepted status write
	// Same positions as o_status
	wire logic [23:0] wd = i_cmd_data;

	// ****************************************************************
	// Non-volatile fields
	// ****************************************************************
	// Power cycle restores defaults, which also frees the power-supply lockdown
	// Limitation: i_rst models a power cycle
	// All fields load in one edge
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			otp_lock_q            <= flp_pkg::FLP_RST_OTP_LOCK;
			status_guard_q        <= flp_pkg::FLP_RST_GUARD;
			quad_lanes_enable_q   <= 1'b0;
			area_guard_q          <= flp_pkg::FLP_RST_AREA;
			invert_protect_flag_q <= 1'b0;
			lock_scheme_select_q  <= 1'b0;
			latency_q             <= 1'b0;
			drive_q               <= flp_pkg::FLP_RST_DRIVE;
			pin_func_q            <= 1'b0;
		end else if (ok_swr) begin
			// Lock bits can only be added, never removed
			otp_lock_q            <= otp_lock_q | {wd[flp_pkg::FLP_POS_LOCK_TWO],
			                                       wd[flp_pkg::FLP_POS_LOCK_ONE]};
			status_guard_q        <= {wd[flp_pkg::FLP_POS_GUARD_HI], wd[flp_pkg::FLP_POS_GUARD_LO]};
			quad_lanes_enable_q   <= wd[flp_pkg::FLP_POS_QUAD];
			area_guard_q          <= wd[flp_pkg::FLP_POS_AREA_LO +: 5];
			invert_protect_flag_q <= wd[flp_pkg::FLP_POS_INVERT];
			lock_scheme_select_q  <= wd[flp_pkg::FLP_POS_SCHEME];
			latency_q             <= wd[flp_pkg::FLP_POS_LATENCY];
			drive_q               <= wd[flp_pkg::FLP_POS_DRIVE_LO +: 2];
			pin_func_q            <= wd[flp_pkg::FLP_POS_PIN_FUNC];
		end
	end

	// ****************************************************************
	// Write latch
	// ****************************************************************
	// Any considered write-class command drops the latch, refused or not
	// Clears win; codes never coincide
	// Arm while busy queues the next write
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			write_latch_flag_q <= 1'b0;
		else if (soft_rst || (live && is_disarm) || wr_try)
			write_latch_flag_q <= 1'b0;
		else if (live && is_arm)
			write_latch_flag_q <= 1'b1;
	end

	// ****************************************************************
	// Busy timer
	// ****************************************************************
	// Fixed length stands in for the array sequencer's real timing
	// A longer time needs a wider counter
	// Loads only when idle: no restart
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			busy_cnt_q <= 8'h00;
		else if (accept)
			busy_cnt_q <= flp_pkg::FLP_OP_CYCLES;
		else if (busy)
			busy_cnt_q <= busy_cnt_q - 8'h01;
	end

	// ****************************************************************
	// Deep sleep and software reset
	// ****************************************************************
	// Sleep is ignored while busy, never cuts an op
	// Only wake or the reset pair leave it
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			deep_sleep_q  <= 1'b0;
			reset_armed_q <= 1'b0;
		end else begin
			if (soft_rst || (live && is_wake))
				deep_sleep_q <= 1'b0;
			else if (live && is_sleep && !busy)
				deep_sleep_q <= 1'b1;
			// The arm only counts for the very next command
			if (live)
				reset_armed_q <= is_rarm;
		end
	end

	// Individual locks come back locked after power-up and software reset
	// Limitation: one lock bit per block
	// Global lock and free are ignored while busy
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			blk_lock_q <= flp_pkg::FLP_RST_BLK_LOCK;
		else if (soft_rst || (live && is_glock && !busy))
			blk_lock_q <= flp_pkg::FLP_RST_BLK_LOCK;
		else if (live && is_gfree && !busy)
			blk_lock_q <= 16'h0000;
	end

	// ****************************************************************
	// Operation report
	// ****************************************************************
	// Registered pulses, one cycle late
	// Kind and address hold the last one
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_op_start    <= 1'b0;
			o_op_kind     <= flp_pkg::FLP_OP_NONE;
			o_op_addr     <= 24'h000000;
			o_cmd_refused <= 1'b0;
		end else begin
			o_op_start    <= accept;
			o_cmd_refused <= wr_try && !accept;
			if (accept) begin
				o_op_kind <= kind_now;
				o_op_addr <= i_cmd_addr;
			end
		end
	end

	// ****************************************************************
	// Status word and pin function
	// ****************************************************************
	// Unused and suspend bits read zero
	// Busy comes straight off the counter
	assign o_status = {pin_func_q, drive_q, 2'h0, lock_scheme_select_q, latency_q, 1'b0,
	                   1'b0, invert_protect_flag_q, 1'b0, otp_lock_q[1], otp_lock_q[0], 1'b0,
	                   quad_lanes_enable_q, status_guard_q[1], status_guard_q[0], area_guard_q,
	                   write_latch_flag_q, busy};
	// Flags mirror the status word; deep sleep has no status bit
	assign o_internal_op_busy  = busy;
	assign o_write_latch_flag  = write_latch_flag_q;
	assign o_deep_sleep        = deep_sleep_q;
	assign o_quad_lines_active = quad_lanes_enable_q;
	assign o_otp_lock_one      = otp_lock_q[0];
	assign o_otp_lock_two      = otp_lock_q[1];

endmodule

// [verif/flp_host_model.sv]
// Host-side model: issues whole, byte-aligned commands to the protection core.
// Assumes the bench calls send from one thread; lines change on falling edges only.
`timescale 1ns/1ps
module flp_host_model (
	input  wire logic   i_clock,
	output logic        o_cmd_valid,
	output logic [7:0]  o_cmd_code,
	output logic [23:0] o_cmd_addr,
	output logic [23:0] o_cmd_data
);
	// Lines start in a non-command pattern
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_code  = 8'hFF;
		o_cmd_addr  = 24'hA5A5A5;
		o_cmd_data  = 24'h5A5A5A;
	end

	// One strobe per command, held for one clock period
	task automatic send(input logic [7:0] c, input logic [23:0] a, input logic [23:0] d);
		@(negedge i_clock);
		o_cmd_valid = 1'b1;
		o_cmd_code  = c;
		o_cmd_addr  = a;
		o_cmd_data  = d;
		@(negedge i_clock);
		o_cmd_valid = 1'b0;
		o_cmd_code  = ~c; // Stale fields are inverted so they never pass as valid
		o_cmd_addr  = ~a;
		o_cmd_data  = ~d;
	endtask
endmodule

// [verif/flp_write_protect_assertions.sv]
// Concurrent checks on the protection core, seen from its ports only.
// Assumes commands arrive as one-cycle strobes on the single core clock.
`timescale 1ns/1ps
module flp_write_protect_assertions (
	input wire logic        i_clock,
	input wire logic        i_rst,
	input wire logic        i_cmd_valid,
	input wire logic [7:0]  i_cmd_code,
	input wire logic        i_wp_n,
	input wire logic [23:0] o_status,
	input wire logic        o_internal_op_busy,
	input wire logic        o_write_latch_flag,
	input wire logic        o_deep_sleep,
	input wire logic        o_quad_lines_active,
	input wire logic        o_otp_lock_one,
	input wire logic        o_otp_lock_two,
	input wire logic        o_op_start,
	input wire logic        o_cmd_refused
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// Command classes; the pin stops guarding once it carries quad data
	wire logic wr_cls;
	wire logic cons;
	wire logic sw_lock;
	wire logic chip_ok;
	assign wr_cls  = i_cmd_code inside {8'h01, 8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h42, 8'h44};
	assign cons    = i_cmd_valid & o_write_latch_flag & ~o_internal_op_busy & ~o_deep_sleep;
	assign sw_lock = o_status[8] | (o_status[7] & ~i_wp_n & ~o_status[9]);
	assign chip_ok = (o_status[4:2] == 3'h0 & ~o_status[14]) | (o_status[4:2] == 3'h7 & o_status[14]);

	sequence s_silent;
		!o_op_start && !o_cmd_refused;
	endsequence
	sequence s_refused;
		o_cmd_refused && !o_op_start;
	endsequence
	sequence s_busy_run;
		o_internal_op_busy [*8] ##1 o_internal_op_busy [*8] ##1 !o_internal_op_busy;
	endsequence

	property p_busy_run;
		o_op_start |-> s_busy_run;
	endproperty
	a_busy_run: assert property (p_busy_run) else $error("busy not high for 16 cycles");
	property p_mirror;
		o_status[0] == o_internal_op_busy && o_status[1] == o_write_latch_flag
			&& o_status[9] == o_quad_lines_active && o_status[12:11] == {o_otp_lock_two, o_otp_lock_one};
	endproperty
	a_mirror: assert property (p_mirror) else $error("status word disagrees with flags");
	property p_idle_ignore;
		i_cmd_valid && wr_cls && !o_write_latch_flag |=> s_silent;
	endproperty
	a_idle_ignore: assert property (p_idle_ignore) else $error("command acted on with latch clear");
	property p_busy_ignore;
		i_cmd_valid && wr_cls && o_internal_op_busy |=> s_silent ##0 $stable(o_write_latch_flag);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) else $error("command acted on while busy");
	property p_arm;
		i_cmd_valid && i_cmd_code == 8'h06 && !o_deep_sleep |=> o_write_latch_flag;
	endproperty
	a_arm: assert property (p_arm) else $error("arm did not set latch");
	property p_disarm;
		(i_cmd_valid && i_cmd_code == 8'h04 && !o_deep_sleep) || (cons && wr_cls) |=> !o_write_latch_flag;
	endproperty
	a_disarm: assert property (p_disarm) else $error("latch not cleared");
	property p_sleep;
		o_deep_sleep && i_cmd_valid && !(i_cmd_code inside {8'hAB, 8'h66, 8'h99})
			|=> s_silent ##0 $stable(o_status) ##0 o_deep_sleep;
	endproperty
	a_sleep: assert property (p_sleep) else $error("command acted on in deep sleep");
	property p_otp;
		o_otp_lock_one |=> o_otp_lock_one;
	endproperty
	a_otp: assert property (p_otp) else $error("lock bit cleared");
	property p_sw_guard;
		cons && i_cmd_code == 8'h01 && sw_lock |=> s_refused ##0 $stable(o_status[8:2]);
	endproperty
	a_sw_guard: assert property (p_sw_guard) else $error("guarded status write taken");
	property p_chip;
		cons && i_cmd_code inside {8'hC7, 8'h60} && !o_status[18] && !chip_ok |=> s_refused;
	endproperty
	a_chip: assert property (p_chip) else $error("chip wipe not refused");
endmodule

bind flp_write_protect flp_write_protect_assertions u_flp_write_protect_assertions (
	.i_clock, .i_rst, .i_cmd_valid, .i_cmd_code, .i_wp_n, .o_status, .o_internal_op_busy,
	.o_write_latch_flag, .o_deep_sleep, .o_quad_lines_active, .o_otp_lock_one, .o_otp_lock_two,
	.o_op_start, .o_cmd_refused
);

// [verif/flp_write_protect_test.sv]
// Self-checking bench for the protection core, driven through the host model.
// Assumes a 250 MHz core clock and that i_rst stands for a power cycle.
`timescale 1ns/1ps
module flp_write_protect_test;
	logic             i_clock = 1'b0;
	logic             i_rst = 1'b1;
	logic             i_wp_n = 1'b1;
	wire logic        cv;
	wire logic [7:0]  cc;
	wire logic [23:0] ca;
	wire logic [23:0] cd;
	wire logic [23:0] st;
	wire logic        busy;
	wire logic        wl;
	wire logic        slp;
	wire logic        quad;
	wire logic        st_go;
	wire logic        refd;
	wire logic        lk1;
	wire logic        lk2;
	wire logic [23:0] oa;
	flp_pkg::flp_op_t kind;
	int               mismatches = 0;
	int               check_count = 0;
	typedef struct packed {logic [7:0] c; logic [4:0] a; logic v; logic [23:0] ad; logic r;} flp_case_t;
	// Area map cases: command, guard field, invert, address, refused
	flp_case_t tbl[13] = '{'{8'h02, 5'h00, 1'b0, 24'h000000, 1'b0}, '{8'h02, 5'h01, 1'b0, 24'h0F0000, 1'b1},
		'{8'h02, 5'h01, 1'b0, 24'h0EFF00, 1'b0}, '{8'hD8, 5'h09, 1'b0, 24'h000000, 1'b1},
		'{8'hD8, 5'h09, 1'b0, 24'h010000, 1'b0}, '{8'h20, 5'h04, 1'b0, 24'h07F000, 1'b0},
		'{8'h20, 5'h05, 1'b0, 24'h000000, 1'b1}, '{8'h20, 5'h11, 1'b0, 24'h0FF000, 1'b1},
		'{8'h52, 5'h1C, 1'b0, 24'h008000, 1'b0}, '{8'h02, 5'h01, 1'b1, 24'h0EFF00, 1'b1},
		'{8'hC7, 5'h07, 1'b1, 24'h000000, 1'b0}, '{8'h60, 5'h01, 1'b0, 24'h000000, 1'b1},
		'{8'hC7, 5'h07, 1'b0, 24'h000000, 1'b1}};

	// Core clock, 4 ns period
	always #2 i_clock = ~i_clock;

	flp_host_model u_flp_host_model (.i_clock(i_clock), .o_cmd_valid(cv), .o_cmd_code(cc), .o_cmd_addr(ca),
		.o_cmd_data(cd));
	flp_write_protect u_flp_write_protect (.i_clock(i_clock), .i_rst(i_rst), .i_cmd_valid(cv), .i_cmd_code(cc),
		.i_cmd_addr(ca), .i_cmd_data(cd), .i_wp_n(i_wp_n), .o_status(st), .o_internal_op_busy(busy),
		.o_write_latch_flag(wl), .o_deep_sleep(slp), .o_quad_lines_active(quad), .o_otp_lock_one(lk1),
		.o_otp_lock_two(lk2), .o_op_start(st_go), .o_op_kind(kind), .o_op_addr(oa), .o_cmd_refused(refd));

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic snd(input logic [7:0] c, input logic [23:0] a = 24'h0, input logic [23:0] d = 24'h0);
		u_flp_host_model.send(c, a, d);
	endtask
	// Bounded wait: a stuck busy flag ends the run instead of hanging it
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 40) begin
			@(negedge i_clock);
			n++;
		end
		if (n == 40) begin
			mismatches++;
			results();
		end
	endtask
	task automatic pwr();
		i_rst = 1'b1;
		repeat (20) @(negedge i_clock);
		i_rst = 1'b0;
	endtask
	task automatic wrs(input logic [23:0] d);
		snd(8'h06);
		snd(8'h01, 24'h0, d);
		wait_idle();
	endtask
	task automatic try(input logic [7:0] c, input logic [23:0] a, input logic r);
		snd(8'h06);
		snd(c, a);
		chk({refd, st_go}, r ? 2'h2 : 2'h1);
		wait_idle();
	endtask

	// Main sequence: reset state, latch rules, guards, area map, sleep
	initial begin
		pwr();
		chk(st, 24'h400000);
		snd(8'h02);
		chk(st_go, 1'b0);
		i_wp_n = 1'b0;
		snd(8'h06);
		snd(8'h01);
		chk({st_go, kind}, {1'b1, flp_pkg::FLP_OP_STATUS});
		wait_idle();
		snd(8'h06);
		snd(8'h02, 24'h000100);
		chk({busy, st_go, kind}, {2'b11, flp_pkg::FLP_OP_PROG});
		chk(oa, 24'h000100);
		snd(8'h06);
		snd(8'h02, 24'h000200);
		chk({st_go, refd, wl}, 3'h1);
		wait_idle();
		chk(busy, 1'b0);
		snd(8'h04);
		chk(wl, 1'b0);
		wrs(24'h000080);
		snd(8'h06);
		snd(8'h01, 24'h0, 24'h000004);
		chk({refd, st[8:2]}, 8'hA0);
		i_wp_n = 1'b1;
		snd(8'h06);
		snd(8'h01, 24'h0, 24'h000004);
		chk(st_go, 1'b1);
		wait_idle();
		chk(st[8:2], 7'h01);
		wrs(24'h000200);
		chk(quad, 1'b1);
		wrs(24'h000000);
		chk(quad, 1'b0);
		foreach (tbl[i]) begin
			wrs(24'(tbl[i].v) << 14 | 24'(tbl[i].a) << 2);
			try(tbl[i].c, tbl[i].ad, tbl[i].r);
		end
		wrs(24'h000800);
		wrs(24'h000000);
		chk(st[12:11], 2'h1);
		try(8'h42, 24'h000000, 1'b1);
		try(8'h42, 24'h001000, 1'b0);
		wrs(24'h001000);
		chk(st[12:11], 2'h3);
		chk({lk2, lk1}, 2'h3);
		snd(8'hB9);
		chk(slp, 1'b1);
		snd(8'h06);
		chk(wl, 1'b0);
		snd(8'hAB);
		chk(slp, 1'b0);
		snd(8'h06);
		snd(8'hB9);
		snd(8'h66);
		snd(8'h99);
		chk({slp, wl}, 2'h0);
		wrs(24'h000180);
		snd(8'h06);
		snd(8'h01);
		chk(refd, 1'b1);
		pwr();
		wrs(24'h000100);
		snd(8'h06);
		snd(8'h01);
		chk(refd, 1'b1);
		pwr();
		chk(st[8:7], 2'h0);
		results();
	end
endmodule
